// *** disk_device.sv ***
// Strobed register access and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "disk_map.svh"
module disk_device
	import disk_pkg::*;
#(
	parameter int unsigned SEC_CYCLES = `CLK_HZ
) (
	// clock and reset
	input wire logic core_clk_in,
	input wire logic soft_reset_bit_in,
	// link from host controller
	disk_link_if.dev link,
	// front panel
	input wire logic eject_button_in,
	// mechanism and status
	output logic media_req_out,
	output logic media_wr_out,
	output logic [27:0] media_lba_out,
	output logic eject_out,
	output logic door_locked_out,
	output logic media_notify_mode_out,
	output logic [3:0] power_mode_out
);
	localparam logic [10:0] SLEEP_SEC = 11'(`SLEEP_MIN * `SEC_PER_MIN);

	dev_state_t st;
	dev_state_t next;
	logic btn_edge;
	logic sec_tick;
	logic [27:0] chs_lba;
	logic chs_ok;
	logic [27:0] lba_sel;
	logic [12:0] divisor;
	logic [12:0] trial;
	logic [10:0] stby_target;

	if (SEC_CYCLES < 2) begin : g_bad_sec
		$error("disk_device: SEC_CYCLES must be at least 2");
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic dev_state_t dev_defaults();
		dev_state_t s;
		s = '0;
		s.cs = CS_READY;
		s.mode = PM_ACTIVE;
		s.scnt = `TF_RESET;
		s.snum = `TF_RESET;
		s.err = `DIAG_PASS;
		s.cyls = `DEF_CYLS;
		s.heads = `DEF_HEADS;
		s.spt = `DEF_SPT;
		return s;
	endfunction

	function automatic logic [7:0] status_byte(input dev_state_t s);
		logic [7:0] b;
		b = 8'h00;
		b[`ST_BSY] = (s.cs != CS_READY);
		b[`ST_DRDY] = (s.cs == CS_READY);
		b[`ST_ERR] = s.erf;
		return b;
	endfunction

	chs_lba_map u_map (
		.cyl_in({st.cylh, st.cyll}),
		.head_in(st.devh[3:0]),
		.sect_in(st.snum),
		.cyls_in(st.cyls),
		.heads_in(st.heads),
		.spt_in(st.spt),
		.lba_out(chs_lba),
		.ok_out(chs_ok)
	);

	assign lba_sel = {st.devh[3:0], st.cylh, st.cyll, st.snum};
	assign divisor = 13'(st.heads) * 13'(st.spt);
	assign trial = {st.div_rem[11:0], st.div_num[20]};
	assign stby_target = 11'(st.tmr_val) * `STBY_UNIT_S;
	// only the second sync stage feeds the edge detector
	assign btn_edge = st.btn_s2 & ~st.btn_d;
	assign sec_tick = (st.pre == 32'(SEC_CYCLES - 1));

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		next = st;
		next.media_req = 1'b0;
		next.eject = 1'b0;
		next.btn_s1 = eject_button_in;
		next.btn_s2 = st.btn_s1;
		next.btn_d = st.btn_s2;

		// register reads, answered one cycle later
		next.rdata = 8'h00;
		if (link.rd) begin
			if (st.mode == PM_SLEEP) begin
				next.rdata = `SLEEP_RDATA;
			end else if (link.ctl_sel && !link.cmd_sel && link.addr == `CTL_DEVCTL) begin
				next.rdata = status_byte(st);
			end else if (link.cmd_sel && !link.ctl_sel) begin
				case (link.addr)
					`TF_ERR: next.rdata = st.err;
					`TF_SCNT: next.rdata = st.scnt;
					`TF_SNUM: next.rdata = st.snum;
					`TF_CYLL: next.rdata = st.cyll;
					`TF_CYLH: next.rdata = st.cylh;
					`TF_DEVH: next.rdata = st.devh;
					`TF_CMD: next.rdata = status_byte(st);
					default: next.rdata = 8'h00;
				endcase
			end
		end

		// inactivity timers, seconds resolution
		next.pre = sec_tick ? 32'h0000_0000 : st.pre + 32'h0000_0001;
		if (sec_tick && st.stby_sec != 11'h7ff) begin
			next.stby_sec = st.stby_sec + 11'h001;
		end
		if (sec_tick && st.idle_sec != 11'h7ff) begin
			next.idle_sec = st.idle_sec + 11'h001;
		end
		if (st.tmr_en && (st.mode == PM_ACTIVE || st.mode == PM_IDLE) && st.stby_sec >= stby_target) begin
			next.mode = PM_STANDBY;
		end
		if (st.mode != PM_SLEEP && st.idle_sec >= SLEEP_SEC) begin
			next.mode = PM_SLEEP;
		end

		unique case (st.cs)
			CS_READY: begin
				// sleep drops every task-file access until a reset
				if (link.wr && link.cmd_sel && !link.ctl_sel && st.mode != PM_SLEEP) begin
					case (link.addr)
						`TF_ERR: next.feat = link.wdata;
						`TF_SCNT: next.scnt = link.wdata;
						`TF_SNUM: next.snum = link.wdata;
						`TF_CYLL: next.cyll = link.wdata;
						`TF_CYLH: next.cylh = link.wdata;
						`TF_DEVH: next.devh = link.wdata;
						`TF_CMD: begin
							next.err = 8'h00;
							next.erf = 1'b0;
							next.pre = 32'h0000_0000;
							next.stby_sec = 11'h000;
							next.idle_sec = 11'h000;
							case (link.wdata)
								`CMD_READ, `CMD_WRITE: begin
									next.mode = PM_ACTIVE;
									// address stays in the task file in the command's own form
									if (st.devh[`DEVH_LBA] ? (lba_sel < 28'(`CAPACITY)) : chs_ok) begin
										next.media_req = 1'b1;
										next.media_wr = (link.wdata == `CMD_WRITE);
										next.media_lba = st.devh[`DEVH_LBA] ? lba_sel : chs_lba;
									end else begin
										next.err[`ER_IDNF] = 1'b1;
										next.erf = 1'b1;
									end
								end
								`CMD_INIT_GEOM: begin
									next.heads = 5'(st.devh[3:0]) + 5'h01;
									next.spt = st.scnt;
									if (st.scnt == 8'h00) begin
										next.err[`ER_ABRT] = 1'b1;
										next.erf = 1'b1;
									end else begin
										next.cs = CS_DIV;
										next.div_num = `CAPACITY;
										next.div_rem = 13'h0000;
										next.div_cnt = `DIV_STEPS;
									end
								end
								`CMD_IDLE_IMM: next.mode = PM_IDLE;
								`CMD_IDLE: begin
									next.mode = PM_IDLE;
									next.tmr_en = (st.scnt != 8'h00);
									next.tmr_val = st.scnt;
								end
								`CMD_STBY_IMM: next.mode = PM_STANDBY;
								`CMD_STBY: begin
									next.mode = PM_STANDBY;
									next.tmr_en = (st.scnt != 8'h00);
									next.tmr_val = st.scnt;
								end
								`CMD_SLEEP: next.mode = PM_SLEEP;
								`CMD_CHK_PWR: begin
									next.scnt = (st.mode == PM_STANDBY) ? `PWR_CODE_STBY :
										(st.mode == PM_IDLE) ? `PWR_CODE_IDLE : `PWR_CODE_ACTIVE;
								end
								`CMD_SET_FEAT: begin
									if (st.feat == `FEAT_NOTIFY_ON) begin
										next.notify = 1'b1;
									end else if (st.feat == `FEAT_NOTIFY_OFF) begin
										next.notify = 1'b0;
									end else begin
										next.err[`ER_ABRT] = 1'b1;
										next.erf = 1'b1;
									end
								end
								// in notify mode lock commands finish good but change nothing
								`CMD_LOCK: next.locked = st.notify ? st.locked : 1'b1;
								`CMD_UNLOCK: next.locked = st.notify ? st.locked : 1'b0;
								`CMD_EJECT: begin
									next.eject = 1'b1;
									next.locked = 1'b0;
									next.eject_pend = 1'b0;
								end
								`CMD_MEDIA_STAT: begin
									if (st.notify) begin
										next.err[`ER_MCR] = st.eject_pend;
										next.erf = st.eject_pend;
										next.eject_pend = 1'b0;
									end else begin
										next.err[`ER_ABRT] = 1'b1;
										next.erf = 1'b1;
									end
								end
								default: begin
									next.err[`ER_ABRT] = 1'b1;
									next.erf = 1'b1;
								end
							endcase
						end
						default: ;
					endcase
				end
			end
			CS_DIV: begin
				// restoring divide, one quotient bit per cycle
				next.div_rem = (trial >= divisor) ? trial - divisor : trial;
				next.div_num = {st.div_num[19:0], trial >= divisor};
				next.div_cnt = st.div_cnt - 5'h01;
				if (st.div_cnt == 5'h01) begin
					next.cs = CS_READY;
					next.cyls = (|next.div_num[20:16]) ? 16'hffff : next.div_num[15:0];
				end
			end
			CS_DIAG: begin
				next.diag_cnt = st.diag_cnt - 4'h1;
				if (st.diag_cnt == 4'h1) begin
					next.cs = CS_READY;
					next.err = `DIAG_PASS;
				end
			end
		endcase

		// panel button; a press beside a clearing status read stays pending
		if (btn_edge) begin
			if (st.notify) begin
				next.eject_pend = 1'b1;
			end else if (!next.locked) begin
				next.eject = 1'b1;
			end
		end

		// soft reset touches interface state and sets active power mode, geometry and notify mode survive
		if (link.wr && link.ctl_sel && !link.cmd_sel && link.addr == `CTL_DEVCTL
			&& link.wdata[`DEVCTL_SOFT_RESET]) begin
			next.cs = CS_READY;
			next.mode = PM_ACTIVE;
			next.feat = 8'h00;
			next.scnt = `TF_RESET;
			next.snum = `TF_RESET;
			next.cyll = 8'h00;
			next.cylh = 8'h00;
			next.devh = 8'h00;
			next.err = `DIAG_PASS;
			next.erf = 1'b0;
			// without this a drive woken from its own sleep would doze off again at once
			next.idle_sec = 11'h000;
		end

		if (link.hard_reset) begin
			next = dev_defaults();
			next.cs = CS_DIAG;
			next.diag_cnt = `DIAG_CYCLES;
			next.btn_s1 = eject_button_in;
			next.btn_s2 = st.btn_s1;
			next.btn_d = st.btn_s2;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (soft_reset_bit_in) begin
			st <= dev_defaults();
		end else begin
			st <= next;
		end
	end

	assign link.rdata = st.rdata;
	assign media_req_out = st.media_req;
	assign media_wr_out = st.media_wr;
	assign media_lba_out = st.media_lba;
	assign eject_out = st.eject;
	assign door_locked_out = st.locked;
	assign media_notify_mode_out = st.notify;
	assign power_mode_out = st.mode;
endmodule // disk_device
`default_nettype wire

// *** disk_map.svh ***
`ifndef DISK_MAP_SVH
`define DISK_MAP_SVH
// Contract
// - commands arrive only through register writes
// - lba bit chooses chs or lba per command
// - status address uses the command's own method
// - default geometry 1945 cylinders, 16 heads, 63 sectors
// - init command derives cylinders from heads, sectors
// - lba accepted below 1961069 sectors
// - lba bit ignored for non-media commands
// - lba is linear chs mapping minus one
// - hard reset runs diagnostics, restores defaults
// - soft reset bit resets interface only
// - media access runs in active mode
// - thirty idle minutes force sleep mode
// - sleep leaves interface inactive, status invalid
// - enabled timer expiry moves active/idle to standby
// - disabled timer never enters standby alone
// - idle commands go idle, idle loads timer
// - standby commands go standby, standby loads timer
// - sleep command ends interface; reset wakes
// - media command from idle/standby returns active
// - set features 95h/31h toggles media notify
// - notify mode ignores eject button and locks
// - notify mode reports eject press via status

// ----------------------------------------
// link register addresses and fields
// ----------------------------------------
`define TF_ERR 3'h1
`define TF_SCNT 3'h2
`define TF_SNUM 3'h3
`define TF_CYLL 3'h4
`define TF_CYLH 3'h5
`define TF_DEVH 3'h6
`define TF_CMD 3'h7
`define CTL_DEVCTL 3'h6
`define DEVH_LBA 6
`define DEVCTL_SOFT_RESET 2
`define ST_BSY 7
`define ST_DRDY 6
`define ST_ERR 0
`define ER_IDNF 4
`define ER_MCR 3
`define ER_ABRT 2
`define DIAG_PASS 8'h01
`define SLEEP_RDATA 8'hff
`define TF_RESET 8'h01

// ----------------------------------------
// command codes and subcodes
// ----------------------------------------
`define CMD_READ 8'h20
`define CMD_WRITE 8'h30
`define CMD_INIT_GEOM 8'h91
`define CMD_STBY_IMM 8'he0
`define CMD_IDLE_IMM 8'he1
`define CMD_STBY 8'he2
`define CMD_IDLE 8'he3
`define CMD_CHK_PWR 8'he5
`define CMD_SLEEP 8'he6
`define CMD_MEDIA_STAT 8'hda
`define CMD_LOCK 8'hde
`define CMD_UNLOCK 8'hdf
`define CMD_EJECT 8'hed
`define CMD_SET_FEAT 8'hef
`define FEAT_NOTIFY_ON 8'h95
`define FEAT_NOTIFY_OFF 8'h31
`define PWR_CODE_ACTIVE 8'hff
`define PWR_CODE_IDLE 8'h80
`define PWR_CODE_STBY 8'h00

// ----------------------------------------
// geometry, timing and host port addresses
// ----------------------------------------
`define DEF_CYLS 16'h0799
`define DEF_HEADS 5'h10
`define DEF_SPT 8'h3f
`define CAPACITY 21'h1d_ec6d
`define DIV_STEPS 5'h15
`define CLK_HZ 32'h0098_9680
`define SLEEP_MIN 11'h01e
`define SEC_PER_MIN 11'h03c
`define STBY_UNIT_S 11'h005
`define DIAG_CYCLES 4'h8
`define HRST_CYCLES 4'h4
`define HOST_DEVCTL 4'h8
`define HOST_CTRL 4'h9

`endif

// *** disk_pkg.sv ***
package disk_pkg;

	typedef enum logic [3:0] {
		PM_ACTIVE = 4'b0001,
		PM_IDLE = 4'b0010,
		PM_STANDBY = 4'b0100,
		PM_SLEEP = 4'b1000
	} power_mode_t;

	typedef enum logic [2:0] {
		CS_READY = 3'b001,
		CS_DIV = 3'b010,
		CS_DIAG = 3'b100
	} ctl_state_t;

	typedef struct packed {
		ctl_state_t cs;
		power_mode_t mode;
		logic [7:0] feat;
		logic [7:0] scnt;
		logic [7:0] snum;
		logic [7:0] cyll;
		logic [7:0] cylh;
		logic [7:0] devh;
		logic [7:0] err;
		logic erf;
		logic [15:0] cyls;
		logic [4:0] heads;
		logic [7:0] spt;
		logic notify;
		logic locked;
		logic eject_pend;
		logic tmr_en;
		logic [7:0] tmr_val;
		logic [31:0] pre;
		logic [10:0] stby_sec;
		logic [10:0] idle_sec;
		logic [20:0] div_num;
		logic [12:0] div_rem;
		logic [4:0] div_cnt;
		logic [3:0] diag_cnt;
		logic [7:0] rdata;
		logic btn_s1;
		logic btn_s2;
		logic btn_d;
		logic media_req;
		logic media_wr;
		logic [27:0] media_lba;
		logic eject;
	} dev_state_t;

	typedef struct packed {
		logic l_cmd;
		logic l_ctl;
		logic [2:0] l_addr;
		logic [7:0] l_wdata;
		logic l_wr;
		logic l_rd;
		logic hrst;
		logic [3:0] hrst_cnt;
		logic [2:0] poll;
		logic cap;
		logic [2:0] cap_addr;
		logic [7:0][7:0] mirror;
		logic [7:0] sw_rdata;
	} host_state_t;

endpackage

// *** disk_link_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface disk_link_if;
	logic hard_reset;
	logic cmd_sel;
	logic ctl_sel;
	logic [2:0] addr;
	logic [7:0] wdata;
	logic wr;
	logic rd;
	logic [7:0] rdata;
	modport dev(input hard_reset, cmd_sel, ctl_sel, addr, wdata, wr, rd, output rdata);
	modport host(output hard_reset, cmd_sel, ctl_sel, addr, wdata, wr, rd, input rdata);
endinterface // disk_link_if
`default_nettype wire

// *** chs_lba_map.sv ***
`timescale 1ns/1ps
`default_nettype none
module chs_lba_map #(
	parameter int CW = 16,
	parameter int HW = 5,
	parameter int SW = 8,
	parameter int LW = 28
) (
	// chs address and translation
	input wire logic [CW-1:0] cyl_in,
	input wire logic [HW-2:0] head_in,
	input wire logic [SW-1:0] sect_in,
	input wire logic [CW-1:0] cyls_in,
	input wire logic [HW-1:0] heads_in,
	input wire logic [SW-1:0] spt_in,
	// result
	output logic [LW-1:0] lba_out,
	output logic ok_out
);
	localparam int PW = CW + HW + SW;
	logic [PW-1:0] trk;

	if (LW > PW || HW < 2) begin : g_bad_width
		$error("chs_lba_map: unsupported widths");
	end

	assign trk = PW'(cyl_in) * PW'(heads_in) + PW'(head_in);
	assign lba_out = LW'(trk * PW'(spt_in) + PW'(sect_in) - PW'(1));
	assign ok_out = (cyl_in < cyls_in) && ({1'b0, head_in} < heads_in)
		&& (sect_in != '0) && (sect_in <= spt_in);
endmodule // chs_lba_map
`default_nettype wire

// *** disk_host.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "disk_map.svh"
module disk_host
	import disk_pkg::*;
(
	// clock and reset
	input wire logic core_clk_in,
	input wire logic soft_reset_bit_in,
	// software port
	input wire logic [3:0] sw_addr_in,
	input wire logic [7:0] sw_wdata_in,
	input wire logic sw_wr_in,
	input wire logic sw_rd_in,
	output logic [7:0] sw_rdata_out,
	// link to drive
	disk_link_if.host link
);
	host_state_t st;
	host_state_t next;

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		next = st;
		next.l_wr = 1'b0;
		next.l_rd = 1'b0;
		next.l_cmd = 1'b0;
		next.l_ctl = 1'b0;

		// every command and parameter goes out as a register write
		if (sw_wr_in && !sw_addr_in[3]) begin
			next.l_wr = 1'b1;
			next.l_cmd = 1'b1;
			next.l_addr = sw_addr_in[2:0];
			next.l_wdata = sw_wdata_in;
		end else if (sw_wr_in && sw_addr_in == `HOST_DEVCTL) begin
			next.l_wr = 1'b1;
			next.l_ctl = 1'b1;
			next.l_addr = `CTL_DEVCTL;
			next.l_wdata = sw_wdata_in;
		end else begin
			// idle cycles poll the task file so software reads never wait
			next.l_rd = 1'b1;
			next.l_cmd = 1'b1;
			next.l_addr = st.poll;
			next.poll = (st.poll == `TF_CMD) ? `TF_ERR : st.poll + 3'h1;
		end
		if (sw_wr_in && sw_addr_in == `HOST_CTRL && sw_wdata_in[0]) begin
			next.hrst = 1'b1;
			next.hrst_cnt = `HRST_CYCLES;
		end else if (st.hrst) begin
			next.hrst_cnt = st.hrst_cnt - 4'h1;
			next.hrst = (st.hrst_cnt != 4'h1);
		end

		// drive answers one cycle after the read
		next.cap = st.l_rd && st.l_cmd;
		next.cap_addr = st.l_addr;
		if (st.cap) begin
			next.mirror[st.cap_addr] = link.rdata;
		end

		next.sw_rdata = 8'h00;
		if (sw_rd_in) begin
			if (!sw_addr_in[3]) begin
				next.sw_rdata = st.mirror[sw_addr_in[2:0]];
			end else if (sw_addr_in == `HOST_DEVCTL) begin
				next.sw_rdata = st.mirror[`TF_CMD];
			end else if (sw_addr_in == `HOST_CTRL) begin
				next.sw_rdata = {7'h00, st.hrst};
			end
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (soft_reset_bit_in) begin
			st <= '0;
		end else begin
			st <= next;
		end
	end

	assign link.hard_reset = st.hrst;
	assign link.cmd_sel = st.l_cmd;
	assign link.ctl_sel = st.l_ctl;
	assign link.addr = st.l_addr;
	assign link.wdata = st.l_wdata;
	assign link.wr = st.l_wr;
	assign link.rd = st.l_rd;
	assign sw_rdata_out = st.sw_rdata;
endmodule // disk_host
`default_nettype wire

// *** disk_power_media_control_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "disk_map.svh"
module disk_power_media_control_assertions #(
	// link silence after which the drive may have slept on its own; keep it below that time
	parameter int unsigned DOZE_CYCLES = 32'h0000_3e80
) (
	// clock and reset
	input wire logic core_clk_in,
	input wire logic soft_reset_bit_in,
	// link signals
	input wire logic hard_reset,
	input wire logic cmd_sel,
	input wire logic ctl_sel,
	input wire logic [2:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [7:0] rdata
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (soft_reset_bit_in);

	// ----------------------------------------
	// helper state
	// ----------------------------------------
	// asleep and fresh are conservative: any command write drops fresh
	// dozy masks the checks that an unseen self-sleep would break
	logic asleep;
	logic fresh;
	logic quiet;
	logic dozy;
	logic soft_wr;
	logic cmd_wr;
	logic [3:0] since_hr;
	logic [15:0] idle_cnt;

	if (DOZE_CYCLES == 0 || DOZE_CYCLES > 32'h0000_ffff) begin : g_bad_doze
		$error("disk_power_media_control_assertions: DOZE_CYCLES out of range");
	end

	assign soft_wr = wr && ctl_sel && addr == `CTL_DEVCTL && wdata[`DEVCTL_SOFT_RESET];
	assign cmd_wr = wr && cmd_sel && addr == `TF_CMD;

	always_ff @(posedge core_clk_in) begin
		if (soft_reset_bit_in) begin
			asleep <= 1'b0;
			fresh <= 1'b1;
			quiet <= 1'b1;
			dozy <= 1'b0;
			since_hr <= 4'hf;
			idle_cnt <= 16'h0000;
		end else if (hard_reset) begin
			asleep <= 1'b0;
			fresh <= 1'b0;
			quiet <= 1'b1;
			dozy <= 1'b0;
			since_hr <= 4'h0;
			idle_cnt <= 16'h0000;
		end else begin
			if (since_hr != 4'hf)
				since_hr <= since_hr + 4'h1;
			if (wr && cmd_sel)
				quiet <= 1'b0;
			if (cmd_wr && wdata == `CMD_SLEEP)
				asleep <= 1'b1;
			if (soft_wr) begin
				asleep <= 1'b0;
				fresh <= 1'b1;
				dozy <= 1'b0;
				idle_cnt <= 16'h0000;
			end else begin
				if (wr && cmd_sel)
					fresh <= 1'b0;
				if (cmd_wr && !asleep && !dozy)
					idle_cnt <= 16'h0000;
				else if (idle_cnt != 16'hffff)
					idle_cnt <= idle_cnt + 16'h0001;
				if ({16'h0000, idle_cnt} >= DOZE_CYCLES)
					dozy <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// properties
	// ----------------------------------------
	sequence hr_pulse;
		hard_reset [*4] ##1 !hard_reset;
	endsequence
	sequence stat_rd;
		rd && cmd_sel && addr == `TF_CMD;
	endsequence
	// seven busy cycles inside the diagnostic window, so a full polling round always lands in it
	sequence early_rd;
		rd && cmd_sel && addr == `TF_CMD && since_hr inside {[1:7]};
	endsequence

	rdata_idle_a: assert property (!$past(rd) |-> rdata == 8'h00) else $error("rdata without read");
	strobe_excl_a: assert property (!(wr && rd)) else $error("write and read together");
	sel_one_a: assert property ((wr || rd) |-> cmd_sel != ctl_sel) else $error("bad select");
	hard_len_a: assert property ($rose(hard_reset) |-> hr_pulse) else $error("hard reset length");
	diag_busy_a: assert property (early_rd |=> rdata[`ST_BSY]) else $error("not busy in diagnostics");
	diag_ready_a: assert property (stat_rd ##0 (since_hr == 4'hf && quiet && !asleep && !dozy)
		|=> !rdata[`ST_BSY]) else $error("busy after diagnostics");
	sleep_read_a: assert property (rd && cmd_sel && asleep |=> rdata == `SLEEP_RDATA) else $error("sleep read");
	soft_clear_a: assert property (rd && cmd_sel && fresh && !dozy
		&& addr inside {`TF_ERR, `TF_SCNT, `TF_SNUM} |=> rdata == `TF_RESET) else $error("task file not cleared");
endmodule // disk_power_media_control_assertions
`default_nettype wire

// *** test_disk_power_media_control.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_disk_power_media_control;
	typedef struct packed {
		logic [7:0] devh, scnt, cylh, cyll, snum, cmd;
		logic [3:0] mode;
		logic req;
		logic [27:0] lba;
		logic err;
	} row_t;
	localparam int NROWS = 14;
	localparam row_t ROWS [NROWS] = '{
		'{8'h40, 8'h00, 8'h00, 8'h00, 8'h00, 8'h20, 4'h1, 1'b1, 28'h0, 1'b0},
		'{8'h40, 8'h00, 8'h1d, 8'hec, 8'h6c, 8'h30, 4'h1, 1'b1, 28'h1d_ec6c, 1'b0},
		'{8'h40, 8'h00, 8'h1d, 8'hec, 8'h6d, 8'h20, 4'h1, 1'b0, 28'h1d_ec6c, 1'b1},
		'{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h20, 4'h1, 1'b1, 28'h0, 1'b0},
		'{8'h0f, 8'h00, 8'h07, 8'h98, 8'h3f, 8'h20, 4'h1, 1'b1, 28'h1d_ea6f, 1'b0},
		'{8'h40, 8'h00, 8'h00, 8'h00, 8'h00, 8'he3, 4'h2, 1'b0, 28'h1d_ea6f, 1'b0},
		'{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'he0, 4'h4, 1'b0, 28'h1d_ea6f, 1'b0},
		'{8'h40, 8'h00, 8'h00, 8'h00, 8'h00, 8'he1, 4'h2, 1'b0, 28'h1d_ea6f, 1'b0},
		'{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'he2, 4'h4, 1'b0, 28'h1d_ea6f, 1'b0},
		'{8'h40, 8'h00, 8'h00, 8'h00, 8'h05, 8'h20, 4'h1, 1'b1, 28'h5, 1'b0},
		'{8'h03, 8'h20, 8'h00, 8'h00, 8'h00, 8'h91, 4'h1, 1'b0, 28'h5, 1'b0},
		'{8'h03, 8'h00, 8'h3b, 8'hd7, 8'h20, 8'h20, 4'h1, 1'b1, 28'h1d_ebff, 1'b0},
		'{8'h00, 8'h00, 8'h3b, 8'hd8, 8'h01, 8'h20, 4'h1, 1'b0, 28'h1d_ebff, 1'b1},
		'{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h20, 4'h1, 1'b1, 28'h80, 1'b0}
	};
	logic clk = 1'b0;
	logic soft_reset_bit = 1'b1;
	logic [3:0] sw_addr = 4'h0;
	logic [7:0] sw_wdata = 8'h00;
	logic sw_wr = 1'b0;
	logic sw_rd = 1'b0;
	logic [7:0] sw_rdata;
	logic button = 1'b0;
	logic media_req_out, media_wr_out, eject_out, door_locked_out, media_notify_mode_out;
	logic [27:0] media_lba_out;
	logic [3:0] power_mode_out;
	int bad_count = 0;
	int cmp_count = 0;
	int req_cnt = 0;
	int ej_cnt = 0;
	int cycles = 0;

	disk_link_if link();
	disk_host disk_host_i (.core_clk_in(clk), .soft_reset_bit_in(soft_reset_bit), .sw_addr_in(sw_addr), .sw_wdata_in(sw_wdata),
		.sw_wr_in(sw_wr), .sw_rd_in(sw_rd), .sw_rdata_out(sw_rdata), .link(link));
	// a short second keeps the standby and sleep timers within the run
	disk_device #(.SEC_CYCLES(10)) disk_device_i (.core_clk_in(clk), .soft_reset_bit_in(soft_reset_bit), .link(link),
		.eject_button_in(button), .media_req_out(media_req_out), .media_wr_out(media_wr_out),
		.media_lba_out(media_lba_out), .eject_out(eject_out), .door_locked_out(door_locked_out),
		.media_notify_mode_out(media_notify_mode_out), .power_mode_out(power_mode_out));
	disk_power_media_control_assertions disk_power_media_control_assertions_i (.core_clk_in(clk),
		.soft_reset_bit_in(soft_reset_bit), .hard_reset(link.hard_reset), .cmd_sel(link.cmd_sel), .ctl_sel(link.ctl_sel),
		.addr(link.addr), .wdata(link.wdata), .wr(link.wr), .rd(link.rd), .rdata(link.rdata));

	initial begin
		forever #50 clk = ~clk;
	end

	always @(posedge clk) begin
		cycles++;
		if (media_req_out === 1'b1)
			req_cnt++;
		if (eject_out === 1'b1)
			ej_cnt++;
		if (cycles == 24000) begin
			bad_count++;
			final_report;
		end
	end

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task final_report;
		if (bad_count == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task chk(input logic [27:0] g, input logic [27:0] e);
		cmp_count++;
		if (g !== e) begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task sw_write(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk);
		sw_addr <= a;
		sw_wdata <= v;
		sw_wr <= 1'b1;
		@(posedge clk);
		sw_wr <= 1'b0;
	endtask
	task rd8(input logic [3:0] a, output logic [7:0] v);
		@(posedge clk);
		sw_addr <= a;
		sw_rd <= 1'b1;
		@(posedge clk);
		sw_rd <= 1'b0;
		@(negedge clk);
		v = sw_rdata;
	endtask
	// the wait covers the divider and the mirror refresh
	task do_cmd(input logic [7:0] c);
		sw_write(4'h7, c);
		repeat (30) @(posedge clk);
	endtask
	task press;
		@(posedge clk);
		button <= 1'b1;
		repeat (4) @(posedge clk);
		button <= 1'b0;
		repeat (4) @(posedge clk);
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		row_t r;
		int n;
		int e;
		logic [7:0] d;
		logic [7:0] p [5];
		repeat (16) @(posedge clk);
		soft_reset_bit <= 1'b0;
		repeat (20) @(posedge clk);
		for (int i = 0; i < NROWS; i++) begin
			r = ROWS[i];
			n = req_cnt;
			p = '{r.scnt, r.snum, r.cyll, r.cylh, r.devh};
			for (int k = 0; k < 5; k++)
				sw_write(4'(k + 2), p[k]);
			do_cmd(r.cmd);
			chk(28'(power_mode_out), 28'(r.mode));
			chk(28'(req_cnt - n), 28'(r.req));
			chk(media_lba_out, r.lba);
			if (r.req)
				chk(28'(media_wr_out), 28'(r.cmd == 8'h30));
			rd8(4'h7, d);
			chk(28'(d[0]), 28'(r.err));
		end
		sw_write(4'h2, 8'h01);
		do_cmd(8'he3);
		repeat (5) @(posedge clk);
		chk(28'(power_mode_out), 28'h2);
		do_cmd(8'he5);
		rd8(4'h2, d);
		chk(28'(d), 28'h80);
		chk(28'(power_mode_out), 28'h2);
		repeat (40) @(posedge clk);
		chk(28'(power_mode_out), 28'h4);
		sw_write(4'h2, 8'h00);
		do_cmd(8'he3);
		repeat (100) @(posedge clk);
		chk(28'(power_mode_out), 28'h2);
		sw_write(4'h1, 8'h95);
		do_cmd(8'hef);
		chk(28'(media_notify_mode_out), 28'h1);
		do_cmd(8'hde);
		chk(28'(door_locked_out), 28'h0);
		rd8(4'h7, d);
		chk(28'(d[0]), 28'h0);
		e = ej_cnt;
		press;
		chk(28'(ej_cnt - e), 28'h0);
		do_cmd(8'hda);
		rd8(4'h1, d);
		chk(28'(d[3]), 28'h1);
		do_cmd(8'hda);
		rd8(4'h7, d);
		chk(28'(d[0]), 28'h0);
		do_cmd(8'hed);
		chk(28'(ej_cnt - e), 28'h1);
		sw_write(4'h1, 8'h55);
		do_cmd(8'hef);
		rd8(4'h1, d);
		chk(28'(d[2]), 28'h1);
		do_cmd(8'he6);
		chk(28'(power_mode_out), 28'h8);
		rd8(4'h2, d);
		chk(28'(d), 28'hff);
		sw_write(4'h8, 8'h04);
		sw_write(4'h8, 8'h00);
		repeat (15) @(posedge clk);
		chk(28'(power_mode_out), 28'h1);
		chk(28'(media_notify_mode_out), 28'h1);
		sw_write(4'h1, 8'h31);
		do_cmd(8'hef);
		chk(28'(media_notify_mode_out), 28'h0);
		do_cmd(8'hde);
		chk(28'(door_locked_out), 28'h1);
		do_cmd(8'hdf);
		chk(28'(door_locked_out), 28'h0);
		sw_write(4'h9, 8'h01);
		rd8(4'h9, d);
		chk(28'(d[0]), 28'h1);
		repeat (30) @(posedge clk);
		p = '{8'h00, 8'h3f, 8'h98, 8'h07, 8'h0f};
		for (int k = 0; k < 5; k++)
			sw_write(4'(k + 2), p[k]);
		do_cmd(8'h20);
		chk(media_lba_out, 28'h1d_ea6f);
		do_cmd(8'he1);
		soft_reset_bit <= 1'b1;
		repeat (16) @(posedge clk);
		soft_reset_bit <= 1'b0;
		repeat (20) @(posedge clk);
		chk(28'(power_mode_out), 28'h1);
		rd8(4'h2, d);
		chk(28'(d), 28'h01);
		// only polling from here on, past thirty minutes of the shortened second
		repeat (18020) @(posedge clk);
		chk(28'(power_mode_out), 28'h8);
		final_report;
	end
endmodule // test_disk_power_media_control
`default_nettype wire
